// ### rtl/lbl_cond_eval.sv
`timescale 1ns/1ps
`default_nettype none
module lbl_cond_eval (
    input wire logic [7:0] op,
    input wire logic [7:0] ccr,
    output logic hit,
    output logic take
);
    import lbl_pkg::*;
    logic n, z, v, c;
    assign n = ccr[CCR_N];
    assign z = ccr[CCR_Z];
    assign v = ccr[CCR_V];
    assign c = ccr[CCR_C];

    always_comb begin
        hit = 1'b1;
        take = 1'b0;
        case (op)
            OP_LB_OVF: take = v;
            OP_LB_GT: take = !(z | (n ^ v));
            OP_LB_LE: take = z | (n ^ v);
            OP_LB_GE: take = !(n ^ v);
            OP_LB_LT: take = n ^ v;
            OP_LB_HI: take = !(c | z);
            OP_LB_LS: take = c | z;
            OP_LB_HS: take = !c;
            OP_LB_LO: take = c;
            default: hit = 1'b0;
        endcase
    end
endmodule
`default_nettype wire

// ### rtl/lbl_exec_unit.sv
`timescale 1ns/1ps
`default_nettype none
module lbl_exec_unit #(
    parameter int ADDR_W = 8
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic iq_valid,
    output logic iq_ready,
    input wire lbl_pkg::lbl_instr_s iq_instr,
    input wire logic [15:0] ea_addr,
    output logic mem_req,
    output logic [15:0] mem_addr,
    input wire logic [7:0] mem_rdata,
    input wire logic mem_ack,
    output logic pc_load,
    output logic [15:0] pc_new,
    output logic done,
    output logic [7:0] acc_a,
    output logic [7:0] acc_b,
    output logic [7:0] ccr
);
    import lbl_pkg::*;

    // ************************************************************
    // decode
    // ************************************************************
    lbl_state_e state_reg, state_next;
    lbl_dest_e dest_reg, dest_next;
    logic [15:0] data_reg, data_next;
    logic [15:0] mem_addr_reg, mem_addr_next;
    logic [15:0] pc_tgt_reg, pc_tgt_next;
    logic [2:0] cnt_reg, cnt_next;
    logic taken_reg, taken_next;
    logic pc_load_reg, pc_load_next;
    logic done_reg, done_next;
    logic [7:0] acc_a_reg, acc_a_next;
    logic [7:0] acc_b_reg, acc_b_next;
    logic [7:0] ccr_reg, ccr_next;
    logic unsup_reg, unsup_next;
    logic ctrl_run_reg, ctrl_run_next;
    logic accept, is_long, br_hit, br_take;
    logic sw_ccr_we, sw_unsup_clr;
    logic [15:0] rel;
    lbl_load_s ld;

    lbl_cond_eval u_cond (
        .op(iq_instr.b1),
        .ccr(ccr_reg),
        .hit(br_hit),
        .take(br_take)
    );

    lbl_load_decode u_ld (
        .op(iq_instr.b0),
        .xb(iq_instr.b1),
        .info(ld)
    );

    assign iq_ready = (state_reg == ST_IDLE) && ctrl_run_reg;
    assign accept = iq_valid && iq_ready;
    assign is_long = (iq_instr.b0 == OP_PREFIX) && br_hit;
    assign rel = {iq_instr.b2, iq_instr.b3};
    assign mem_req = (state_reg == ST_RD_HI) || (state_reg == ST_RD_LO);

    // ************************************************************
    // execution sequence
    // ************************************************************
    always_comb begin
        state_next = state_reg;
        dest_next = dest_reg;
        data_next = data_reg;
        mem_addr_next = mem_addr_reg;
        pc_tgt_next = pc_tgt_reg;
        cnt_next = cnt_reg;
        taken_next = taken_reg;
        pc_load_next = 1'b0;
        done_next = 1'b0;
        acc_a_next = acc_a_reg;
        acc_b_next = acc_b_reg;
        ccr_next = ccr_reg;
        unsup_next = unsup_reg;
        // software updates first so that hardware results win
        if (sw_ccr_we) begin
            ccr_next = wdata[7:0];
        end
        if (sw_unsup_clr) begin
            unsup_next = 1'b0;
        end
        case (state_reg)
            ST_IDLE: begin
                if (accept && is_long) begin
                    taken_next = br_take;
                    pc_tgt_next = iq_instr.addr + BR_OFFSET;
                    if (br_take) begin
                        pc_tgt_next = iq_instr.addr + BR_OFFSET + rel;
                    end
                    cnt_next = br_take ? CYC_TAKEN - 3'h1 : CYC_NOT_TAKEN - 3'h1;
                    state_next = ST_BRANCH;
                end else if (accept && ld.hit) begin
                    dest_next = ld.dest;
                    pc_tgt_next = iq_instr.addr + {13'h0000, ld.len};
                    if (ld.amode == AM_IMM) begin
                        data_next = {iq_instr.b1, iq_instr.b2};
                        state_next = ST_WB;
                    end else begin
                        mem_addr_next = ea_addr;
                        state_next = ST_RD_HI;
                    end
                end else if (accept) begin
                    // outside this slice: no state change, flagged and done pulsed
                    unsup_next = 1'b1;
                    done_next = 1'b1;
                end
            end
            ST_BRANCH: begin
                // branch leaves the flags untouched; only a bus write to REG_CCR can change them here
                if (cnt_reg == 3'h1) begin
                    pc_load_next = 1'b1;
                    done_next = 1'b1;
                    state_next = ST_IDLE;
                end else begin
                    cnt_next = cnt_reg - 3'h1;
                end
            end
            ST_RD_HI: begin
                if (mem_ack) begin
                    data_next[15:8] = mem_rdata;
                    if (dest_reg == DEST_D) begin
                        mem_addr_next = mem_addr_reg + 16'h0001;
                        state_next = ST_RD_LO;
                    end else begin
                        state_next = ST_WB;
                    end
                end
            end
            ST_RD_LO: begin
                if (mem_ack) begin
                    data_next[7:0] = mem_rdata;
                    state_next = ST_WB;
                end
            end
            ST_WB: begin
                if (dest_reg == DEST_D) begin
                    acc_a_next = data_reg[15:8];
                    acc_b_next = data_reg[7:0];
                    ccr_next[CCR_N] = data_reg[15];
                    ccr_next[CCR_Z] = (data_reg == 16'h0000);
                end else begin
                    if (dest_reg == DEST_A) begin
                        acc_a_next = data_reg[15:8];
                    end else begin
                        acc_b_next = data_reg[15:8];
                    end
                    ccr_next[CCR_N] = data_reg[15];
                    ccr_next[CCR_Z] = (data_reg[15:8] == 8'h00);
                end
                // only N, Z and V are written back
                ccr_next[CCR_V] = 1'b0;
                pc_load_next = 1'b1;
                done_next = 1'b1;
                state_next = ST_IDLE;
            end
            default: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= ST_IDLE;
            dest_reg <= DEST_A;
            data_reg <= 16'h0000;
            mem_addr_reg <= 16'h0000;
            pc_tgt_reg <= 16'h0000;
            cnt_reg <= 3'h0;
            taken_reg <= 1'b0;
            pc_load_reg <= 1'b0;
            done_reg <= 1'b0;
            acc_a_reg <= 8'h00;
            acc_b_reg <= 8'h00;
            ccr_reg <= CCR_RST;
            unsup_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            dest_reg <= dest_next;
            data_reg <= data_next;
            mem_addr_reg <= mem_addr_next;
            pc_tgt_reg <= pc_tgt_next;
            cnt_reg <= cnt_next;
            taken_reg <= taken_next;
            pc_load_reg <= pc_load_next;
            done_reg <= done_next;
            acc_a_reg <= acc_a_next;
            acc_b_reg <= acc_b_next;
            ccr_reg <= ccr_next;
            unsup_reg <= unsup_next;
        end
    end

    assign mem_addr = mem_addr_reg;
    assign pc_load = pc_load_reg;
    assign pc_new = pc_tgt_reg;
    assign done = done_reg;
    assign acc_a = acc_a_reg;
    assign acc_b = acc_b_reg;
    assign ccr = ccr_reg;

    // ************************************************************
    // register bus
    // ************************************************************
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic rvalid_reg, rvalid_next;
    logic [1:0] rresp_reg, rresp_next;
    logic [31:0] rdata_reg, rdata_next;
    logic wr_fire, rd_fire;
    logic [7:0] wa, ra;

    // address and data are taken together, which keeps one write slot
    assign awready = awvalid && wvalid && !bvalid_reg;
    assign wready = awready;
    assign arready = !rvalid_reg;
    assign wr_fire = awready;
    assign rd_fire = arvalid && arready;
    assign wa = 8'(awaddr);
    assign ra = 8'(araddr);
    assign sw_ccr_we = wr_fire && (wa == REG_CCR) && wstrb[0];
    assign sw_unsup_clr = wr_fire && (wa == REG_STAT) && wstrb[0] && wdata[1];

    always_comb begin
        ctrl_run_next = ctrl_run_reg;
        bvalid_next = bvalid_reg && !bready;
        bresp_next = bresp_reg;
        rvalid_next = rvalid_reg && !rready;
        rresp_next = rresp_reg;
        rdata_next = rdata_reg;
        if (wr_fire) begin
            bvalid_next = 1'b1;
            bresp_next = RESP_OKAY;
            if (wa == REG_CTRL) begin
                if (wstrb[0]) begin
                    ctrl_run_next = wdata[0];
                end
            end else if (wa == REG_CCR || wa == REG_STAT) begin
                bresp_next = RESP_OKAY;
            end else if (wa == REG_ACC || wa == REG_PC) begin
                bresp_next = RESP_OKAY;
            end else begin
                bresp_next = RESP_SLVERR;
            end
        end
        if (rd_fire) begin
            rvalid_next = 1'b1;
            rresp_next = RESP_OKAY;
            rdata_next = 32'h0000_0000;
            if (ra == REG_CTRL) begin
                rdata_next[0] = ctrl_run_reg;
            end else if (ra == REG_CCR) begin
                rdata_next[7:0] = ccr_reg;
            end else if (ra == REG_ACC) begin
                rdata_next[15:0] = {acc_a_reg, acc_b_reg};
            end else if (ra == REG_PC) begin
                rdata_next[15:0] = pc_tgt_reg;
            end else if (ra == REG_STAT) begin
                rdata_next[2:0] = {taken_reg, unsup_reg, state_reg != ST_IDLE};
            end else begin
                rresp_next = RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_run_reg <= CTRL_RST;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            rvalid_reg <= 1'b0;
            rresp_reg <= RESP_OKAY;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ctrl_run_reg <= ctrl_run_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rresp_reg <= rresp_next;
            rdata_reg <= rdata_next;
        end
    end

    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign rvalid = rvalid_reg;
    assign rresp = rresp_reg;
    assign rdata = rdata_reg;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    chk_ovf_branch_test: assert property (
        accept && is_long && iq_instr.b1 == OP_LB_OVF
        |=> taken_reg == $past(ccr_reg[CCR_V]))
        else $error("overflow branch decision wrong");

    chk_branch_target: assert property (
        accept && is_long && br_take
        |=> pc_tgt_reg == $past(iq_instr.addr) + BR_OFFSET + $past(rel))
        else $error("taken branch target wrong");

    chk_taken_cycles: assert property (
        accept && is_long && br_take |=> !done_reg[*3] ##1 (done_reg && pc_load_reg))
        else $error("taken branch not four cycles");

    chk_untaken_cycles: assert property (
        accept && is_long && !br_take |=> !done_reg[*2] ##1 done_reg)
        else $error("untaken branch not three cycles");

    chk_signed_cond: assert property (
        is_long && iq_instr.b1 == OP_LB_GT
        |-> br_take == !(ccr_reg[CCR_Z] | (ccr_reg[CCR_N] ^ ccr_reg[CCR_V])))
        else $error("signed greater decode wrong");

    chk_unsigned_cond: assert property (
        is_long && iq_instr.b1 == OP_LB_HI
        |-> br_take == !(ccr_reg[CCR_C] | ccr_reg[CCR_Z]))
        else $error("unsigned higher decode wrong");

    chk_load_byte_a: assert property (
        state_reg == ST_RD_HI && mem_ack && dest_reg == DEST_A
        |-> ##2 acc_a_reg == $past(mem_rdata, 2))
        else $error("accumulator A not loaded");

    chk_byte_flags: assert property (
        state_reg == ST_WB && dest_reg != DEST_D
        |=> ccr_reg[CCR_N] == $past(data_reg[15]) && !ccr_reg[CCR_V]
            && ccr_reg[CCR_Z] == ($past(data_reg[15:8]) == 8'h00))
        else $error("byte load flags wrong");

    chk_double_load: assert property (
        state_reg == ST_WB && dest_reg == DEST_D
        |=> {acc_a_reg, acc_b_reg} == $past(data_reg)
            && ccr_reg[CCR_Z] == ($past(data_reg) == 16'h0000))
        else $error("double load wrong");

    chk_imm_double: assert property (
        accept && iq_instr.b0 == OP_ACCD_IMM
        |-> ##2 {acc_a_reg, acc_b_reg} == {$past(iq_instr.b1, 2), $past(iq_instr.b2, 2)})
        else $error("immediate double load wrong");

    chk_idx2_length: assert property (
        accept && !is_long && iq_instr.b0 == OP_ACCA_IDX
        && iq_instr.b1[7:5] == 3'b111 && !iq_instr.b1[2] && iq_instr.b1[1]
        |=> pc_tgt_reg == $past(iq_instr.addr) + 16'h0004)
        else $error("indexed 16-bit length wrong");

    chk_flags_kept: assert property (
        (state_reg == ST_BRANCH && !sw_ccr_we) |=> $stable(ccr_reg))
        else $error("branch altered flags");

    cov_taken: cover property (accept && is_long && br_take);
    cov_untaken: cover property (accept && is_long && !br_take);
    cov_double_mem: cover property (state_reg == ST_RD_LO && mem_ack);
    cov_bus_write: cover property (sw_ccr_we);
endmodule
`default_nettype wire

// ### rtl/lbl_load_decode.sv
`timescale 1ns/1ps
`default_nettype none
module lbl_load_decode (
    input wire logic [7:0] op,
    input wire logic [7:0] xb,
    output lbl_pkg::lbl_load_s info
);
    import lbl_pkg::*;
    logic [2:0] idx_len;

    // 9-bit offset adds one byte, 16-bit and indirect 16-bit add two
    always_comb begin
        idx_len = LEN_IDX;
        if (xb[7:5] == 3'b111 && !xb[2]) begin
            idx_len = xb[1] ? LEN_IDX + 3'h2 : LEN_IDX + 3'h1;
        end
    end

    always_comb begin
        info = '{hit: 1'b1, dest: DEST_A, amode: AM_MEM, len: LEN_DIR};
        case (op)
            OP_ACCA_IMM: info = '{1'b1, DEST_A, AM_IMM, LEN_IMM8};
            OP_ACCA_DIR: info = '{1'b1, DEST_A, AM_MEM, LEN_DIR};
            OP_ACCA_EXT: info = '{1'b1, DEST_A, AM_MEM, LEN_EXT};
            OP_ACCA_IDX: info = '{1'b1, DEST_A, AM_MEM, idx_len};
            OP_ACCB_IMM: info = '{1'b1, DEST_B, AM_IMM, LEN_IMM8};
            OP_ACCB_DIR: info = '{1'b1, DEST_B, AM_MEM, LEN_DIR};
            OP_ACCB_EXT: info = '{1'b1, DEST_B, AM_MEM, LEN_EXT};
            OP_ACCB_IDX: info = '{1'b1, DEST_B, AM_MEM, idx_len};
            OP_ACCD_IMM: info = '{1'b1, DEST_D, AM_IMM, LEN_IMM16};
            OP_ACCD_DIR: info = '{1'b1, DEST_D, AM_MEM, LEN_DIR};
            OP_ACCD_EXT: info = '{1'b1, DEST_D, AM_MEM, LEN_EXT};
            OP_ACCD_IDX: info = '{1'b1, DEST_D, AM_MEM, idx_len};
            default: info.hit = 1'b0;
        endcase
    end
endmodule
`default_nettype wire

// ### rtl/lbl_pkg.sv
package lbl_pkg;

    // ************************************************************
    // opcodes
    // ************************************************************
    localparam logic [7:0] OP_PREFIX = 8'h18;
    localparam logic [7:0] OP_LB_OVF = 8'h29;
    localparam logic [7:0] OP_LB_GT = 8'h2E;
    localparam logic [7:0] OP_LB_LE = 8'h2F;
    localparam logic [7:0] OP_LB_GE = 8'h2C;
    localparam logic [7:0] OP_LB_LT = 8'h2D;
    localparam logic [7:0] OP_LB_HI = 8'h22;
    localparam logic [7:0] OP_LB_LS = 8'h23;
    localparam logic [7:0] OP_LB_HS = 8'h24;
    localparam logic [7:0] OP_LB_LO = 8'h25;
    localparam logic [7:0] OP_ACCA_IMM = 8'h86;
    localparam logic [7:0] OP_ACCA_DIR = 8'h96;
    localparam logic [7:0] OP_ACCA_EXT = 8'hB6;
    localparam logic [7:0] OP_ACCA_IDX = 8'hA6;
    localparam logic [7:0] OP_ACCB_IMM = 8'hC6;
    localparam logic [7:0] OP_ACCB_DIR = 8'hD6;
    localparam logic [7:0] OP_ACCB_EXT = 8'hF6;
    localparam logic [7:0] OP_ACCB_IDX = 8'hE6;
    localparam logic [7:0] OP_ACCD_IMM = 8'hCC;
    localparam logic [7:0] OP_ACCD_DIR = 8'hDC;
    localparam logic [7:0] OP_ACCD_EXT = 8'hFC;
    localparam logic [7:0] OP_ACCD_IDX = 8'hEC;

    // ************************************************************
    // lengths, timing, flags
    // ************************************************************
    localparam logic [15:0] BR_OFFSET = 16'h0004;
    localparam logic [2:0] LEN_IMM8 = 3'h2;
    localparam logic [2:0] LEN_IMM16 = 3'h3;
    localparam logic [2:0] LEN_DIR = 3'h2;
    localparam logic [2:0] LEN_EXT = 3'h3;
    localparam logic [2:0] LEN_IDX = 3'h2;
    localparam logic [2:0] CYC_TAKEN = 3'h4;
    localparam logic [2:0] CYC_NOT_TAKEN = 3'h3;
    localparam int CCR_C = 0;
    localparam int CCR_V = 1;
    localparam int CCR_Z = 2;
    localparam int CCR_N = 3;
    localparam logic [7:0] CCR_RST = 8'hD0;

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_CCR = 8'h04;
    localparam logic [7:0] REG_ACC = 8'h08;
    localparam logic [7:0] REG_PC = 8'h0C;
    localparam logic [7:0] REG_STAT = 8'h10;
    localparam logic CTRL_RST = 1'b1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {DEST_A, DEST_B, DEST_D} lbl_dest_e;
    typedef enum logic {AM_IMM, AM_MEM} lbl_amode_e;
    typedef enum logic [2:0] {ST_IDLE, ST_BRANCH, ST_RD_HI, ST_RD_LO, ST_WB} lbl_state_e;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] b0;
        logic [7:0] b1;
        logic [7:0] b2;
        logic [7:0] b3;
    } lbl_instr_s;

    typedef struct packed {
        logic hit;
        lbl_dest_e dest;
        lbl_amode_e amode;
        logic [2:0] len;
    } lbl_load_s;

endpackage

// ### verif/lbl_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module lbl_mem_model (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic slow,
    input wire logic mem_req,
    input wire logic [15:0] mem_addr,
    output logic [7:0] mem_rdata,
    output logic mem_ack
);
    // ************************************************************
    // byte store: fixed hash of the address
    // ************************************************************
    logic [7:0] rd_reg;
    logic wait_reg;
    // outside the ack cycle the bus shows the inverse, never stale data
    assign mem_rdata = mem_ack ? rd_reg : ~rd_reg;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mem_ack <= 1'b0;
            wait_reg <= 1'b0;
            rd_reg <= 8'h00;
        end else begin
            mem_ack <= 1'b0;
            if (mem_req && !mem_ack) begin
                wait_reg <= slow && !wait_reg;
                if (!slow || wait_reg) begin
                    mem_ack <= 1'b1;
                    rd_reg <= mem_addr[15:8] ^ mem_addr[7:0] ^ 8'h3c;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ### verif/test_long_branch_and_accum_load.sv
`timescale 1ns/1ps
`default_nettype none
module test_long_branch_and_accum_load;
    import lbl_pkg::*;
    logic clk, arst_n, awvalid, wvalid, bready, arvalid, rready, iq_valid, slow, mem_ack;
    logic awready, wready, bvalid, arready, rvalid, iq_ready, mem_req, pc_load, done;
    logic isd, isb, pl;
    logic [7:0] awaddr, araddr, mem_rdata, acc_a, acc_b, ccr, ex_a, ex_b, c, op, b1, v8, ex_c;
    logic [31:0] wdata, rdata, seed, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rs;
    logic [15:0] ea_addr, mem_addr, pc_new, off, v16, pc_x, eax, len;
    lbl_instr_s iq_instr;
    int err_total, checks, n;
    logic [7:0] br_ops [9] = '{OP_LB_OVF, OP_LB_GT, OP_LB_LE, OP_LB_GE, OP_LB_LT,
        OP_LB_HI, OP_LB_LS, OP_LB_HS, OP_LB_LO};
    logic [7:0] ld_ops [12] = '{OP_ACCA_IMM, OP_ACCA_DIR, OP_ACCA_EXT, OP_ACCA_IDX,
        OP_ACCB_IMM, OP_ACCB_DIR, OP_ACCB_EXT, OP_ACCB_IDX,
        OP_ACCD_IMM, OP_ACCD_DIR, OP_ACCD_EXT, OP_ACCD_IDX};

    lbl_exec_unit #(.ADDR_W(8)) i_lbl_exec_unit (.clk, .arst_n, .awaddr, .awvalid, .awready,
        .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready, .iq_valid, .iq_ready, .iq_instr,
        .ea_addr, .mem_req, .mem_addr, .mem_rdata, .mem_ack, .pc_load, .pc_new, .done,
        .acc_a, .acc_b, .ccr);
    lbl_mem_model i_lbl_mem_model (.clk, .arst_n, .slow, .mem_req, .mem_addr, .mem_rdata,
        .mem_ack);

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [31:0] nxt(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    function automatic logic [7:0] mem(input logic [15:0] a);
        return a[15:8] ^ a[7:0] ^ 8'h3c;
    endfunction
    function automatic logic tk(input logic [7:0] o, input logic [7:0] f);
        case (o)
            OP_LB_OVF: return f[1];
            OP_LB_GT: return !(f[2] | (f[3] ^ f[1]));
            OP_LB_LE: return f[2] | (f[3] ^ f[1]);
            OP_LB_GE: return !(f[3] ^ f[1]);
            OP_LB_LT: return f[3] ^ f[1];
            OP_LB_HI: return !(f[0] | f[2]);
            OP_LB_LS: return f[0] | f[2];
            OP_LB_HS: return !f[0];
            default: return f[0];
        endcase
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        if (err_total == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do @(posedge clk); while (!awready);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do @(posedge clk); while (!bvalid);
        rs = bresp;
        bready <= 1'b0;
    endtask
    task automatic axr(input logic [7:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clk); while (!rvalid);
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask
    task automatic run(input logic [7:0] b0, input logic [7:0] q1, input logic [7:0] q2,
        input logic [7:0] q3);
        @(posedge clk);
        iq_instr <= {pc_x, b0, q1, q2, q3};
        slow <= seed[3];
        iq_valid <= 1'b1;
        do @(posedge clk); while (!iq_ready);
        iq_valid <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (!done && n < 40);
        pl = pc_load;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        finish_test;
    end

    initial begin
        {arst_n, awvalid, wvalid, bready, arvalid, rready, iq_valid, slow} = '0;
        {awaddr, araddr, wdata, ea_addr, iq_instr, ex_a, ex_b} = '0;
        wstrb = 4'hf;
        seed = 32'hf3e0;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        chk(ccr, CCR_RST);
        axr(REG_CTRL);
        chk(rd[0], CTRL_RST);
        axr(8'h40);
        chk(rs, RESP_SLVERR);
        axw(REG_CTRL, 32'h0000_0000);
        @(posedge clk);
        chk(iq_ready, 1'b0);
        axw(REG_CTRL, 32'h0000_0001);
        foreach (br_ops[i]) repeat (4) begin
            seed = nxt(seed);
            c = seed[7:0];
            off = seed[23:8];
            pc_x = 16'(nxt(seed));
            axw(REG_CCR, {24'h0, c});
            run(OP_PREFIX, br_ops[i], off[15:8], off[7:0]);
            // done is seen four (taken) or three (untaken) edges after the accept edge
            chk(n, tk(br_ops[i], c) ? int'(CYC_TAKEN) : int'(CYC_NOT_TAKEN));
            // target wraps at 16 bits like the program counter
            v16 = pc_x + BR_OFFSET + (tk(br_ops[i], c) ? off : 16'h0);
            chk(pc_new, v16);
            chk(pl, 1'b1);
            chk(ccr, c);
        end
        foreach (ld_ops[i]) repeat (3) begin
            seed = nxt(seed);
            op = ld_ops[i];
            c = seed[7:0];
            pc_x = 16'(nxt(seed));
            eax = seed[8] ? 16'h003c : seed[31:16];
            ea_addr <= eax;
            b1 = seed[10] ? 8'h00 : seed[23:16];
            if (op[5:4] == 2'b10) b1 = seed[9] ? 8'he2 : 8'h05;
            axw(REG_CCR, {24'h0, c});
            run(op, b1, seed[15:8], seed[7:0]);
            v16 = op[5:4] == 2'b00 ? {b1, seed[15:8]} : {mem(eax), mem(eax + 16'h1)};
            v8 = v16[15:8];
            isd = op[3:0] == 4'hc;
            isb = op[6] && !isd;
            if (isd) {ex_a, ex_b} = v16;
            else if (isb) ex_b = v8;
            else ex_a = v8;
            len = (op[5:4] == 2'b11 || (op[5:4] == 2'b00 && isd)) ? 16'h3 : 16'h2;
            if (b1 == 8'he2 && op[5:4] == 2'b10) len = 16'h4;
            ex_c = {c[7:4], isd ? v16[15] : v8[7], isd ? v16 == 0 : v8 == 0, 1'b0, c[0]};
            chk(acc_a, ex_a);
            chk(acc_b, ex_b);
            chk(ccr, ex_c);
            chk(pc_new, 16'(pc_x + len));
            chk(pl, 1'b1);
        end
        // opcode outside the slice: one cycle, no effect, sticky flag
        run(OP_PREFIX, 8'h20, 8'h12, 8'h34);
        chk(n, 32'h0000_0001);
        chk(pl, 1'b0);
        chk(ccr, ex_c);
        axr(REG_STAT);
        chk(rd[1], 1'b1);
        axw(REG_STAT, 32'h0000_0002);
        axr(REG_STAT);
        chk(rd[1], 1'b0);
        axr(REG_PC);
        chk(rd[15:0], 16'(pc_x + len));
        axw(8'h40, 32'h0000_0000);
        chk(rs, RESP_SLVERR);
        axr(REG_ACC);
        chk(rd[15:0], {ex_a, ex_b});
        finish_test;
    end
endmodule
`default_nettype wire
